// File: design/mmc_regs.vh
`ifndef MMC_REGS_VH
`define MMC_REGS_VH

// Data-space addresses in general mode
`define MMC_ADDR_INDIRECT 5'h00
`define MMC_ADDR_TIMER 5'h01
`define MMC_ADDR_PCL 5'h02
`define MMC_ADDR_STATUS 5'h03
`define MMC_ADDR_BANK 5'h04
`define MMC_ADDR_PORT_A_DATA 5'h05
`define MMC_ADDR_PORT_B_DATA 5'h06
`define MMC_ADDR_GPR_FIRST 5'h07
`define MMC_GPR_COUNT 25

// Program-memory constants
`define MMC_PC_W 10
`define MMC_RESET_VECTOR 10'h3FF
`define MMC_IRQ_VECTOR 10'h3FE
`define MMC_PC_STEP 10'h001
`define MMC_PC_SKIP 10'h002
`define MMC_CONFIG_ADDR 12'h800

// Status register fields
`define MMC_ST_PAGE 5
`define MMC_ST_TIMEOUT 4
`define MMC_ST_POWERDOWN 3
`define MMC_ST_ALU_HI 2

// Configuration word fields
`define MMC_CFG_OSC_HI 1
`define MMC_CFG_OSC_LO 0
`define MMC_CFG_WDT_EN 2
`define MMC_CFG_CODE_PROT 3
`define MMC_CFG_MODE 4
`define MMC_CFG_LV_HI 6
`define MMC_CFG_LV_LO 5
`define MMC_LV_2V 2'h2
`define MMC_LV_4V 2'h0

// Timer/watchdog control fields
`define MMC_SEL_RESET 6'h3F
`define MMC_SEL_PS_HI 2
`define MMC_SEL_ASSIGN 3
`define MMC_SEL_EDGE 4
`define MMC_SEL_SOURCE 5
`define MMC_PS_TOP 3'h7

`endif

// File: design/mmc_memory_map.v
`timescale 1ns/1ns
`include "mmc_regs.vh"

module mmc_memory_map (
    input wire core_clk, // 20 MHz core clock
    input wire resetn, // Asynchronous reset, active low
    input wire [6:0] fuseWord, // Configuration word as stored at 800H
    input wire instStep, // One instruction retired, pulse
    input wire skipTaken, // Retired instruction skips the next one
    input wire shortCall, // Short call, 8-bit operand in jumpTarget
    input wire shortGoto, // Short goto, 9-bit operand in jumpTarget
    input wire longJump, // Long call or long goto, 10-bit operand
    input wire returnLoad, // Return: jumpTarget holds popped address
    input wire [9:0] jumpTarget, // Operand or return address
    input wire irqTake, // Core requests interrupt entry
    input wire selectWrite, // Select instruction strobe
    input wire [7:0] accumulator, // Accumulator value for select
    input wire [4:0] dataAddr, // Direct data address
    input wire dataWrite, // Data write strobe
    input wire dataRead, // Data read strobe
    input wire [7:0] dataWdata, // Write data
    input wire [2:0] aluFlags, // Zero, digit carry, carry from the ALU
    input wire aluFlagsLoad, // Update ALU flags, pulse
    input wire timeoutFlagN, // Watchdog time-out flag, active low
    input wire powerDownFlagN, // Power-down flag, active low
    input wire watchdogRawTick, // Watchdog oscillator tick, pulse
    input wire extTimerClk, // External timer clock pin
    input wire [3:0] portAPins, // Port A pin levels
    input wire [7:0] portBPins, // Port B pin levels
    output reg [9:0] fetchAddr, // Program fetch address
    output reg [7:0] dataRdata, // Read data, valid the cycle after dataRead
    output reg irqAccepted, // Interrupt vector taken, pulse
    output reg [1:0] oscillatorTypeSelect, // Oscillator type
    output reg watchdogEnableBit, // Watchdog enabled
    output reg codeProtectOn, // Code protection active
    output reg advancedMode, // Operating mode is advanced
    output reg [1:0] lowVoltageLevelSelect, // Low-voltage reset level code
    output reg lowVoltageCodeInvalid, // Forbidden voltage code loaded
    output reg configValid, // Configuration captured after reset
    output reg [5:0] timerWatchdogControl, // Current control register
    output reg [7:0] timerCount, // Timer count value
    output reg watchdogTick, // Prescaled watchdog tick, pulse
    output reg [3:0] portAData, // Port A output latch
    output reg [7:0] portBData // Port B output latch
);

    // Page, ALU flags and bank pointer; timeout/powerdown are live inputs
    reg statusPage;
    reg [2:0] statusAlu;
    reg [7:0] bankPointer;
    reg [7:0] gpr [0:`MMC_GPR_COUNT-1];
    reg [7:0] prescaler;
    reg extSync1;
    reg extSync2;
    reg extLast;
    reg [3:0] portASync1;
    reg [3:0] portASync2;
    reg [7:0] portBSync1;
    reg [7:0] portBSync2;
    reg [9:0] next_fetchAddr;
    reg [7:0] next_rdata;
    wire [4:0] effAddr;
    wire effZero;
    wire extRise;
    wire extFall;
    wire timerSource;
    wire prescaleToWdt;
    wire [7:0] timerMask;
    wire [7:0] wdtMask;
    wire prescaleTick;
    wire timerTick;
    wire timerWrite;
    integer i;

    // Terminal-count mask for a prescale code; timer ratios are one step up, except code 7, capped at the watchdog's 1:128
    function [7:0] ratio_mask;
        input [2:0] code;
        input forTimer;
        reg [3:0] shift;
        begin
            shift = {1'b0, code} + {3'h0, forTimer};
            if (shift > {1'b0, `MMC_PS_TOP}) begin
                shift = {1'b0, `MMC_PS_TOP};
            end
            ratio_mask = 8'hFF >> (4'h8 - shift);
        end
    endfunction

    // Map a direct address to a general register index
    function [4:0] gpr_index;
        input [4:0] addr;
        begin
            gpr_index = addr - `MMC_ADDR_GPR_FIRST;
        end
    endfunction

    assign effAddr = (dataAddr == `MMC_ADDR_INDIRECT) ? bankPointer[4:0] : dataAddr;
    assign effZero = (effAddr == `MMC_ADDR_INDIRECT);

    // Configuration captured at the first edge after reset release
    // configuration word fields
    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            configValid <= 1'b0;
            oscillatorTypeSelect <= 2'h0;
            watchdogEnableBit <= 1'b0;
            codeProtectOn <= 1'b1;
            advancedMode <= 1'b0;
            lowVoltageLevelSelect <= `MMC_LV_4V;
            lowVoltageCodeInvalid <= 1'b0;
        end else if (!configValid) begin
            configValid <= 1'b1;
            oscillatorTypeSelect <= fuseWord[`MMC_CFG_OSC_HI:`MMC_CFG_OSC_LO];
            watchdogEnableBit <= fuseWord[`MMC_CFG_WDT_EN];
            codeProtectOn <= ~fuseWord[`MMC_CFG_CODE_PROT];
            advancedMode <= fuseWord[`MMC_CFG_MODE];
            lowVoltageLevelSelect <= fuseWord[`MMC_CFG_LV_HI:`MMC_CFG_LV_LO];
            lowVoltageCodeInvalid <= (fuseWord[`MMC_CFG_LV_HI:`MMC_CFG_LV_LO] != `MMC_LV_2V) &&
                                     (fuseWord[`MMC_CFG_LV_HI:`MMC_CFG_LV_LO] != `MMC_LV_4V);
        end
    end

    // Next program counter; a data write to the counter outranks sequencing
    always @* begin
        next_fetchAddr = fetchAddr;
        if (dataWrite && effAddr == `MMC_ADDR_PCL && !effZero) begin
            // page bit forms the high bit
            next_fetchAddr = {statusPage, 1'b0, dataWdata};
        end else if (irqTake && advancedMode) begin
            next_fetchAddr = `MMC_IRQ_VECTOR;
        end else if (instStep) begin
            if (longJump) begin
                next_fetchAddr = jumpTarget;
            end else if (returnLoad) begin
                next_fetchAddr = jumpTarget;
            end else if (shortGoto) begin
                next_fetchAddr = {statusPage, jumpTarget[8:0]};
            end else if (shortCall) begin
                next_fetchAddr = {statusPage, 1'b0, jumpTarget[7:0]};
            end else if (skipTaken) begin
                next_fetchAddr = fetchAddr + `MMC_PC_SKIP;
            end else begin
                next_fetchAddr = fetchAddr + `MMC_PC_STEP;
            end
        end
    end

    // Program counter register
    // start at reset vector
    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            fetchAddr <= `MMC_RESET_VECTOR;
            irqAccepted <= 1'b0;
        end else begin
            fetchAddr <= next_fetchAddr;
            irqAccepted <= irqTake && advancedMode &&
                           !(dataWrite && effAddr == `MMC_ADDR_PCL && !effZero);
        end
    end

    // Read mux; the window alone reads zero when the pointer is zero
    always @* begin
        next_rdata = 8'h00;
        if (!effZero) begin
            case (effAddr)
                `MMC_ADDR_TIMER: next_rdata = timerCount;
                `MMC_ADDR_PCL: next_rdata = fetchAddr[7:0];
                `MMC_ADDR_STATUS: next_rdata = {2'h0, statusPage, timeoutFlagN, powerDownFlagN, statusAlu};
                `MMC_ADDR_BANK: next_rdata = bankPointer;
                `MMC_ADDR_PORT_A_DATA: next_rdata = {4'h0, portASync2};
                `MMC_ADDR_PORT_B_DATA: next_rdata = portBSync2;
                default: next_rdata = gpr[gpr_index(effAddr)];
            endcase
        end
    end

    // Registered read data
    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            dataRdata <= 8'h00;
        end else if (dataRead) begin
            dataRdata <= next_rdata;
        end
    end

    // Data-space writes; status ALU bits also follow the ALU
    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            statusPage <= 1'b0;
            statusAlu <= 3'h0;
            bankPointer <= 8'h00;
            portAData <= 4'h0;
            portBData <= 8'h00;
            for (i = 0; i < `MMC_GPR_COUNT; i = i + 1) begin
                gpr[i] <= 8'h00;
            end
        end else begin
            if (aluFlagsLoad) begin
                statusAlu <= aluFlags;
            end
            // writes ignored when pointer is zero
            if (dataWrite && !effZero) begin
                case (effAddr)
                    `MMC_ADDR_TIMER, `MMC_ADDR_PCL: begin
                    end
                    `MMC_ADDR_STATUS: begin
                        statusPage <= dataWdata[`MMC_ST_PAGE];
                        if (!aluFlagsLoad) begin
                            statusAlu <= dataWdata[`MMC_ST_ALU_HI:0];
                        end
                    end
                    `MMC_ADDR_BANK: bankPointer <= dataWdata;
                    `MMC_ADDR_PORT_A_DATA: portAData <= dataWdata[3:0];
                    `MMC_ADDR_PORT_B_DATA: portBData <= dataWdata;
                    default: gpr[gpr_index(effAddr)] <= dataWdata;
                endcase
            end
        end
    end

    // Control register is loaded only by the select instruction
    // default 3FH until written
    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            timerWatchdogControl <= `MMC_SEL_RESET;
        end else if (selectWrite) begin
            timerWatchdogControl <= accumulator[5:0];
        end
    end

    // Pin synchronisers; first stages feed only second stages
    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            extSync1 <= 1'b0;
            extSync2 <= 1'b0;
            extLast <= 1'b0;
            portASync1 <= 4'h0;
            portASync2 <= 4'h0;
            portBSync1 <= 8'h00;
            portBSync2 <= 8'h00;
        end else begin
            extSync1 <= extTimerClk;
            extSync2 <= extSync1;
            extLast <= extSync2;
            portASync1 <= portAPins;
            portASync2 <= portASync1;
            portBSync1 <= portBPins;
            portBSync2 <= portBSync1;
        end
    end

    // Edge detection after the synchroniser adds two cycles of latency
    assign extRise = extSync2 & ~extLast;
    assign extFall = ~extSync2 & extLast;

    assign timerSource = timerWatchdogControl[`MMC_SEL_SOURCE] ?
                         (timerWatchdogControl[`MMC_SEL_EDGE] ? extFall : extRise) : instStep;

    assign prescaleToWdt = timerWatchdogControl[`MMC_SEL_ASSIGN];

    assign timerMask = ratio_mask(timerWatchdogControl[`MMC_SEL_PS_HI:0], 1'b1);
    assign wdtMask = ratio_mask(timerWatchdogControl[`MMC_SEL_PS_HI:0], 1'b0);

    // Shared prescaler input follows whichever side owns it
    assign prescaleTick = prescaleToWdt ? watchdogRawTick : timerSource;
    assign timerWrite = dataWrite && !effZero && (effAddr == `MMC_ADDR_TIMER);
    assign timerTick = prescaleToWdt ? timerSource :
                       (prescaleTick && ((prescaler & timerMask) == timerMask));

    // Shared prescaler; a timer write clears it while the timer owns it, so the next period is whole
    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            prescaler <= 8'h00;
        end else if (timerWrite && !prescaleToWdt) begin
            prescaler <= 8'h00;
        end else if (prescaleTick) begin
            prescaler <= prescaler + 8'h01;
        end
    end

    // Timer count; a software write takes priority over a tick
    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            timerCount <= 8'h00;
        end else if (timerWrite) begin
            timerCount <= dataWdata;
        end else if (timerTick) begin
            timerCount <= timerCount + 8'h01;
        end
    end

    // Watchdog tick: raw when the timer owns the prescaler, else divided
    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            watchdogTick <= 1'b0;
        end else if (!prescaleToWdt) begin
            watchdogTick <= watchdogRawTick;
        end else begin
            watchdogTick <= watchdogRawTick && ((prescaler & wdtMask) == wdtMask);
        end
    end

endmodule // mmc_memory_map

// File: bench/mmc_memory_map_chk.sv
`timescale 1ns/1ns
module mmc_memory_map_chk (
    input wire core_clk, // Core clock
    input wire resetn, // Reset, low
    input wire [6:0] fuseWord, // Fuse image
    input wire instStep, // Retire pulse
    input wire skipTaken, // Skip
    input wire shortCall, // Short call
    input wire shortGoto, // Short goto
    input wire longJump, // Long jump
    input wire returnLoad, // Return
    input wire [9:0] jumpTarget, // Target
    input wire irqTake, // Irq request
    input wire selectWrite, // Select strobe
    input wire [7:0] accumulator, // Select data
    input wire [4:0] dataAddr, // Data address
    input wire dataWrite, // Write strobe
    input wire [9:0] fetchAddr, // Fetch address
    input wire irqAccepted, // Irq taken
    input wire [1:0] oscillatorTypeSelect, // Oscillator
    input wire watchdogEnableBit, // Watchdog on
    input wire codeProtectOn, // Protect on
    input wire advancedMode, // Mode
    input wire [1:0] lowVoltageLevelSelect, // Level
    input wire lowVoltageCodeInvalid, // Bad level
    input wire configValid, // Config loaded
    input wire [5:0] timerWatchdogControl // Control
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!resetn);
    // Anything that beats the plain step
    wire pcWrite = dataWrite && dataAddr == 5'h02;
    wire jumpAny = longJump || returnLoad || shortGoto || shortCall || pcWrite || irqTake;

    a_reset_vector: assert property (!configValid |-> fetchAddr == 10'h3FF && timerWatchdogControl == 6'h3F)
        else $error("fetch or control not at reset value");
    a_pc_step: assert property (instStep && !skipTaken && !jumpAny |=> fetchAddr == $past(fetchAddr) + 10'h001)
        else $error("plain step wrong");
    a_pc_skip: assert property (instStep && skipTaken && !jumpAny |=> fetchAddr == $past(fetchAddr) + 10'h002)
        else $error("skip step wrong");
    a_long_jump: assert property (instStep && longJump && !pcWrite && !irqTake |=> fetchAddr == $past(jumpTarget))
        else $error("long jump wrong");
    a_page_goto: assert property (instStep && shortGoto && !longJump && !returnLoad && !pcWrite && !irqTake
        |=> ((fetchAddr ^ $past(jumpTarget)) & 10'h1FF) == 10'h000)
        else $error("short goto operand wrong");
    a_irq_general: assert property (configValid && !advancedMode && irqTake |=> !irqAccepted)
        else $error("irq taken in general mode");
    a_irq_vector: assert property (advancedMode && irqTake && !pcWrite |=> fetchAddr == 10'h3FE && irqAccepted)
        else $error("irq vector wrong");
    a_config_decode: assert property (configValid |-> {oscillatorTypeSelect, watchdogEnableBit, codeProtectOn,
        advancedMode, lowVoltageLevelSelect, lowVoltageCodeInvalid} == {fuseWord[1:0], fuseWord[2], ~fuseWord[3],
        fuseWord[4], fuseWord[6:5], fuseWord[5]})
        else $error("config decode wrong");
    a_select_load: assert property (selectWrite |=> {2'b00, timerWatchdogControl} == ($past(accumulator) & 8'h3F))
        else $error("select load wrong");
    a_control_hold: assert property (!selectWrite |=> $stable(timerWatchdogControl))
        else $error("control changed without select");

    c_irq: cover property (irqAccepted);
    c_long: cover property (instStep && longJump);
    c_select: cover property (selectWrite);
endmodule // mmc_memory_map_chk

bind mmc_memory_map mmc_memory_map_chk mmc_memory_map_chk_i (.*);

// File: bench/tb.sv
`timescale 1ns/1ns
module tb;
    reg core_clk = 1'b0, resetn = 1'b0, instStep = 1'b0, skipTaken = 1'b0, shortCall = 1'b0, shortGoto = 1'b0;
    reg longJump = 1'b0, returnLoad = 1'b0, irqTake = 1'b0, selectWrite = 1'b0, dataWrite = 1'b0, dataRead = 1'b0;
    reg aluFlagsLoad = 1'b0, timeoutFlagN = 1'b1, powerDownFlagN = 1'b1, watchdogRawTick = 1'b0, extTimerClk = 1'b0;
    reg [6:0] fuseWord = 7'h00;
    reg [9:0] jumpTarget = 10'h000;
    reg [7:0] accumulator = 8'h00, dataWdata = 8'h00, portBPins = 8'h00;
    reg [4:0] dataAddr = 5'h00;
    reg [2:0] aluFlags = 3'h0;
    reg [3:0] portAPins = 4'h0;
    wire [9:0] fetchAddr;
    wire [7:0] dataRdata, timerCount, portBData;
    wire [5:0] timerWatchdogControl;
    wire [3:0] portAData;
    wire [1:0] oscillatorTypeSelect, lowVoltageLevelSelect;
    wire irqAccepted, watchdogEnableBit, codeProtectOn, advancedMode, lowVoltageCodeInvalid, configValid, watchdogTick;
    int fails = 0, samples_checked = 0, pcM, page, n;
    byte unsigned mem[$];
    reg [7:0] r, d;
    reg [6:0] f;

    mmc_memory_map mmc_memory_map_i (.*);

    // 20 MHz clock
    initial forever #25 core_clk = ~core_clk;

    task automatic tick;
        @(posedge core_clk);
    endtask
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // Strobes drop with one idle edge so tasks may follow each other
    task automatic wr(input logic [4:0] ad, input logic [7:0] dt);
        dataAddr <= ad;
        dataWdata <= dt;
        dataWrite <= 1'b1;
        tick;
        dataWrite <= 1'b0;
        tick;
    endtask
    task automatic rd(input logic [4:0] ad);
        dataAddr <= ad;
        dataRead <= 1'b1;
        tick;
        dataRead <= 1'b0;
        tick;
        r = dataRdata;
    endtask
    task automatic sel(input logic [7:0] acc);
        accumulator <= acc;
        selectWrite <= 1'b1;
        tick;
        selectWrite <= 1'b0;
        tick;
        chk(timerWatchdogControl, acc[5:0]);
    endtask
    // Sequencer model, priority long, return, goto, call, skip
    task automatic inst(input logic [4:0] k, input logic [9:0] t);
        {longJump, returnLoad, shortGoto, shortCall, skipTaken} <= k;
        jumpTarget <= t;
        instStep <= 1'b1;
        tick;
        instStep <= 1'b0;
        {longJump, returnLoad, shortGoto, shortCall, skipTaken} <= 5'h00;
        tick;
        if (k[4] || k[3]) pcM = t;
        else if (k[2]) pcM = page * 512 + t[8:0];
        else if (k[1]) pcM = page * 512 + t[7:0];
        else pcM = (pcM + 1 + k[0]) % 1024;
        chk(fetchAddr, pcM[9:0]);
    endtask
    task automatic results;
        $display("checks=%0d fails=%0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // Hang guard, far beyond four passes
    initial begin
        repeat (40000) tick;
        fails++;
        results;
    end

    // One pass per oscillator and level code, mode alternating
    initial begin
        void'($urandom(69));
        for (int p = 0; p < 4; p++) begin
            f = $urandom;
            f[1:0] = p[1:0];
            f[6:5] = p[1:0];
            f[4] = p[0];
            resetn <= 1'b0;
            fuseWord <= f;
            {timeoutFlagN, powerDownFlagN, portAPins, portBPins} <= $urandom;
            repeat (4) tick;
            chk(fetchAddr, 10'h3FF);
            chk(timerWatchdogControl, 6'h3F);
            resetn <= 1'b1;
            repeat (2) tick;
            chk({configValid, oscillatorTypeSelect, watchdogEnableBit, codeProtectOn, advancedMode}, {1'b1, f[1:0], f[2], !f[3], f[4]});
            chk({lowVoltageLevelSelect, lowVoltageCodeInvalid}, {f[6:5], f[5]});
            pcM = 1023;
            page = 0;
            inst(5'h00, 10'h000);
            page = $urandom % 2;
            wr(5'h03, page[0] ? 8'h20 : 8'h00);
            // Every sequencer kind, from long jump down to plain step
            for (int i = 0; i < 6; i++) inst(5'h10 >> i, $urandom);
            aluFlags <= $urandom;
            aluFlagsLoad <= 1'b1;
            tick;
            aluFlagsLoad <= 1'b0;
            rd(5'h03);
            chk(r, {2'b00, page[0], timeoutFlagN, powerDownFlagN, aluFlags});
            d = $urandom;
            wr(5'h02, d);
            pcM = page * 512 + d;
            chk(fetchAddr, pcM[9:0]);
            // Model of the general registers, first entry at address 07
            mem.delete();
            for (int a = 7; a < 32; a++) begin
                mem.push_back(8'($urandom));
                wr(a[4:0], mem[a - 7]);
            end
            // Every general register read back through the window
            for (int a = 7; a < 32; a++) begin
                wr(5'h04, a[7:0]);
                rd(5'h00);
                chk(r, mem[a - 7]);
            end
            wr(5'h04, 8'h00);
            wr(5'h00, 8'hA5);
            rd(5'h00);
            chk(r, 8'h00);
            wr(5'h01, d);
            rd(5'h01);
            chk(r, d);
            wr(5'h06, d);
            wr(5'h05, d);
            chk({portBData, portAData}, {d, d[3:0]});
            // Port reads show the synchronised pin levels, not the latches
            rd(5'h05);
            chk(r, {4'h0, portAPins});
            rd(5'h06);
            chk(r, portBPins);
            irqTake <= 1'b1;
            tick;
            irqTake <= 1'b0;
            #1 chk(irqAccepted, f[4]);
            tick;
            if (f[4]) pcM = 10'h3FE;
            chk(fetchAddr, pcM[9:0]);
            // Prescaler to watchdog at 1:1 then 1:2; the tick stands for the cycle after each raw tick
            for (int w = 0; w < 2; w++) begin
                sel(8'h08 | w[7:0]);
                n = 0;
                repeat (8) begin
                    watchdogRawTick <= 1'b1;
                    tick;
                    watchdogRawTick <= 1'b0;
                    repeat (3) begin
                        #1 n += watchdogTick;
                        tick;
                    end
                end
                chk(n, 8 >> w);
            end
            // Timer on instruction cycles at 1:2 and 1:4
            for (int c = 0; c < 2; c++) begin
                sel(c[7:0]);
                wr(5'h01, 8'h00);
                repeat (8) inst(5'h00, 10'h000);
                repeat (4) tick;
                chk(timerCount, 8 >> (c + 1));
            end
            // External pin, one edge polarity counted at a time
            for (int e = 0; e < 2; e++) begin
                extTimerClk <= 1'b0;
                sel(e[0] ? 8'h38 : 8'h28);
                repeat (6) tick;
                wr(5'h01, 8'h00);
                extTimerClk <= 1'b1;
                repeat (6) tick;
                chk(timerCount, e[0] ? 8'h00 : 8'h01);
                extTimerClk <= 1'b0;
                repeat (6) tick;
                chk(timerCount, 8'h01);
            end
        end
        results;
    end
endmodule // tb
